// File: tile_status_debug_registers.sv
// Processor status register bank of one tile, with debug capture and resource watchpoints.
`timescale 1ns/1ps
`include "tile_status_cfg.svh"

module tile_status_debug_registers #(
    parameter int NUM_WATCH = 4,
    parameter int NUM_CORES = 8,
    parameter int NUM_SLOTS = 4,
    parameter int NUM_SCRATCH = 8,
    parameter logic [31:0] BOOT_STATUS = 32'h00000000,
    parameter logic [31:0] SECURITY_CONFIG = 32'h00000000
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire tile_status_pkg::ps_req_s psReq,
    output logic [31:0] psRdata,
    output logic psRvalid,
    output logic psDenied,
    input wire tile_status_pkg::res_access_s resAccess,
    input wire logic [3:0][15:0] ringCount,
    input wire logic debugExit,
    output logic debugActive,
    output logic [7:0] coreSuspend,
    output logic [NUM_WATCH-1:0] watchHit,
    output logic [31:0] ramBase,
    output logic [31:0] vectorBase,
    output logic [31:0] tileControl,
    output logic [31:0] ringOscControl
);
    import tile_status_pkg::*;

    // ----------------------------------------
    // Request decode
    // ----------------------------------------
    // Debug-only registers sit at 0x10 and above; outside debug they refuse access.
    logic [7:0] addr;
    logic wrEn;
    logic rdEn;
    logic dbgRegion;
    logic dbgOk;
    logic [3:0] slot;
    logic scratchSel;
    logic slotOk;
    logic ctrlSel;
    assign addr = psReq.addr;
    assign dbgRegion = addr >= `PS_DEBUG_SAVED_STATUS;
    assign dbgOk = !dbgRegion || psReq.debugMode;
    assign wrEn = psReq.write && dbgOk;
    assign rdEn = psReq.read && dbgOk;
    assign slot = addr[3:0];
    assign scratchSel = addr[7:3] == 5'h04;
    assign slotOk = slot < NUM_SLOTS;
    // Only 0x9C to 0x9F hold watch controls, so everything above them stays unmapped.
    assign ctrlSel = (addr & 8'hFC) == `PS_RES_WATCH_CTRL_BASE;

    // ----------------------------------------
    // Plain registers
    // ----------------------------------------
    logic [31:0] ramBase_r;
    logic [31:0] vectorBase_r;
    logic [31:0] tileControl_r;
    logic [31:0] ringOscControl_r;
    logic [31:0] savedStatus_r;
    logic [31:0] savedPc_r;
    logic [31:0] savedSp_r;
    logic [31:0] fetchOpOne_r;
    logic [31:0] fetchOpTwo_r;
    logic [31:0] intType_r;
    logic [31:0] intData_r;
    logic [31:0] coreControl_r;
    logic [31:0] scratch_r [NUM_SCRATCH];
    logic [31:0] ibpAddr_r [NUM_SLOTS];
    logic [31:0] ibpCtrl_r [NUM_SLOTS];
    logic [31:0] dwOne_r [NUM_SLOTS];
    logic [31:0] dwTwo_r [NUM_SLOTS];
    logic [31:0] dbpCtrl_r [NUM_SLOTS];
    logic [31:0] rwMask_r [NUM_WATCH];
    logic [31:0] rwValue_r [NUM_WATCH];
    logic [31:0] rwCtrl_r [NUM_WATCH];
    logic [15:0] ringSamp_r [4];
    dbg_state_e state_r;
    logic [2:0] stopCore_r;

    // ----------------------------------------
    // Watchpoint compare
    // ----------------------------------------
    logic [NUM_WATCH-1:0] hit;
    logic anyHit;
    logic captureEn;
    genvar g;
    generate
        for (g = 0; g < NUM_WATCH; g++)
        begin : gWatch
            logic eqMatch;
            logic coreOn;
            logic maskWr;
            logic valueWr;
            logic ctrlWr;
            assign eqMatch = (resAccess.resourceId & rwMask_r[g]) == rwValue_r[g];
            assign coreOn = rwCtrl_r[g][`RW_CTRL_CORE_LSB + resAccess.core];
            assign hit[g] = resAccess.valid && (state_r == RUN_ST) && rwCtrl_r[g][`RW_CTRL_ENABLE_BIT]
                && coreOn && (eqMatch ^ rwCtrl_r[g][`RW_CTRL_SENSE_BIT]);
            assign maskWr = wrEn && (addr == `PS_RES_WATCH_MASK_BASE + 8'(g));
            assign valueWr = wrEn && (addr == `PS_RES_WATCH_VALUE_BASE + 8'(g));
            assign ctrlWr = wrEn && (addr == `PS_RES_WATCH_CTRL_BASE + 8'(g));

            // Each watchpoint owns its registers, so one entry's write never disturbs another's compare.
            always_ff @(posedge clk_sys)
            begin
                if (!rst_n)
                begin
                    rwMask_r[g] <= `REG_RESET_ZERO;
                    rwValue_r[g] <= `REG_RESET_ZERO;
                    rwCtrl_r[g] <= `REG_RESET_ZERO;
                end
                else
                begin
                    if (maskWr)
                    begin
                        rwMask_r[g] <= psReq.wdata;
                    end
                    if (valueWr)
                    begin
                        rwValue_r[g] <= psReq.wdata;
                    end
                    if (ctrlWr)
                    begin
                        // Only the core, sense and enable bits are kept, so reserved bits always read zero.
                        rwCtrl_r[g] <= psReq.wdata & `RW_CTRL_WRITE_MASK;
                    end
                end
            end
        end
    endgenerate
    assign anyHit = |hit;
    assign captureEn = (state_r == RUN_ST) && anyHit;

    // ----------------------------------------
    // Debug state
    // ----------------------------------------
    // Hits are masked outside the run state, so a later hit cannot overwrite a capture until debugExit returns to it.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state_r <= RUN_ST;
            stopCore_r <= 3'h0;
        end
        else
        begin
            unique case (state_r)
                RUN_ST:
                begin
                    if (anyHit)
                    begin
                        state_r <= DEBUG_ST;
                        stopCore_r <= resAccess.core;
                    end
                end
                DEBUG_ST:
                begin
                    if (debugExit)
                    begin
                        state_r <= RUN_ST;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Register writes and capture
    // ----------------------------------------
    // The capture on debug entry takes priority over a software write in the same cycle.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ramBase_r <= `REG_RESET_ZERO;
            vectorBase_r <= `REG_RESET_ZERO;
            tileControl_r <= `REG_RESET_ZERO;
            ringOscControl_r <= `REG_RESET_ZERO;
            savedStatus_r <= `REG_RESET_ZERO;
            savedPc_r <= `REG_RESET_ZERO;
            savedSp_r <= `REG_RESET_ZERO;
            fetchOpOne_r <= `REG_RESET_ZERO;
            fetchOpTwo_r <= `REG_RESET_ZERO;
            intType_r <= `REG_RESET_ZERO;
            intData_r <= `REG_RESET_ZERO;
            coreControl_r <= `REG_RESET_ZERO;
            for (int i = 0; i < NUM_SCRATCH; i++)
            begin
                scratch_r[i] <= `REG_RESET_ZERO;
            end
            for (int i = 0; i < NUM_SLOTS; i++)
            begin
                ibpAddr_r[i] <= `REG_RESET_ZERO;
                ibpCtrl_r[i] <= `REG_RESET_ZERO;
                dwOne_r[i] <= `REG_RESET_ZERO;
                dwTwo_r[i] <= `REG_RESET_ZERO;
                dbpCtrl_r[i] <= `REG_RESET_ZERO;
            end
        end
        else
        begin
            if (wrEn)
            begin
                unique case (addr)
                    `PS_RAM_BASE: ramBase_r <= psReq.wdata;
                    `PS_VECTOR_BASE: vectorBase_r <= psReq.wdata;
                    `PS_TILE_CONTROL: tileControl_r <= psReq.wdata;
                    `PS_RING_OSC_CONTROL: ringOscControl_r <= psReq.wdata;
                    `PS_DEBUG_SAVED_STATUS: savedStatus_r <= psReq.wdata;
                    `PS_DEBUG_SAVED_PC: savedPc_r <= psReq.wdata;
                    `PS_DEBUG_SAVED_SP: savedSp_r <= psReq.wdata;
                    `PS_DEBUG_FETCH_OP_ONE: fetchOpOne_r <= psReq.wdata;
                    `PS_DEBUG_FETCH_OP_TWO: fetchOpTwo_r <= psReq.wdata;
                    `PS_DEBUG_INT_TYPE: intType_r <= psReq.wdata;
                    `PS_DEBUG_INT_DATA: intData_r <= psReq.wdata;
                    `PS_DEBUG_CORE_CONTROL: coreControl_r <= psReq.wdata;
                    default:
                    begin
                        if (scratchSel)
                        begin
                            scratch_r[addr[2:0]] <= psReq.wdata;
                        end
                        if (slotOk)
                        begin
                            unique case (addr[7:4])
                                4'h3: ibpAddr_r[slot[1:0]] <= psReq.wdata;
                                4'h4: ibpCtrl_r[slot[1:0]] <= psReq.wdata;
                                4'h5: dwOne_r[slot[1:0]] <= psReq.wdata;
                                4'h6: dwTwo_r[slot[1:0]] <= psReq.wdata;
                                4'h7: dbpCtrl_r[slot[1:0]] <= psReq.wdata;
                                default: ;
                            endcase
                        end
                    end
                endcase
            end
            if (captureEn)
            begin
                savedStatus_r <= resAccess.savedStatusWord;
                savedPc_r <= resAccess.savedProgramCounter;
                savedSp_r <= resAccess.savedStackPointer;
            end
        end
    end

    // ----------------------------------------
    // Ring oscillator sampling
    // ----------------------------------------
    // No reset branch: the last counts must still be readable after a system reset.
    genvar r;
    generate
        for (r = 0; r < 4; r++)
        begin : gRing
            // Each count is taken straight in, as the oscillator counters run on this clock.
            always_ff @(posedge clk_sys)
            begin
                ringSamp_r[r] <= ringCount[r];
            end
        end
    endgenerate

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    logic [31:0] rdMux;
    always_comb
    begin
        rdMux = `REG_RESET_ZERO;
        unique case (addr)
            `PS_RAM_BASE: rdMux = ramBase_r;
            `PS_VECTOR_BASE: rdMux = vectorBase_r;
            `PS_TILE_CONTROL: rdMux = tileControl_r;
            `PS_TILE_BOOT_STATUS: rdMux = BOOT_STATUS;
            `PS_SECURITY_CONFIG: rdMux = SECURITY_CONFIG;
            `PS_RING_OSC_CONTROL: rdMux = ringOscControl_r;
            `PS_RING_OSC_COUNT_A: rdMux = {16'h0000, ringSamp_r[0]};
            `PS_RING_OSC_TILE_WIRE: rdMux = {16'h0000, ringSamp_r[1]};
            `PS_RING_OSC_PERIPH_CELL: rdMux = {16'h0000, ringSamp_r[2]};
            `PS_RING_OSC_PERIPH_WIRE: rdMux = {16'h0000, ringSamp_r[3]};
            `PS_DEBUG_SAVED_STATUS: rdMux = savedStatus_r;
            `PS_DEBUG_SAVED_PC: rdMux = savedPc_r;
            `PS_DEBUG_SAVED_SP: rdMux = savedSp_r;
            `PS_DEBUG_FETCH_OP_ONE: rdMux = fetchOpOne_r;
            `PS_DEBUG_FETCH_OP_TWO: rdMux = fetchOpTwo_r;
            `PS_DEBUG_INT_TYPE: rdMux = intType_r;
            `PS_DEBUG_INT_DATA: rdMux = intData_r;
            `PS_DEBUG_CORE_CONTROL: rdMux = coreControl_r;
            default:
            begin
                if (scratchSel)
                begin
                    rdMux = scratch_r[addr[2:0]];
                end
                if (slotOk)
                begin
                    unique case (addr[7:4])
                        4'h3: rdMux = ibpAddr_r[slot[1:0]];
                        4'h4: rdMux = ibpCtrl_r[slot[1:0]];
                        4'h5: rdMux = dwOne_r[slot[1:0]];
                        4'h6: rdMux = dwTwo_r[slot[1:0]];
                        4'h7: rdMux = dbpCtrl_r[slot[1:0]];
                        4'h8: rdMux = rwMask_r[slot[1:0]];
                        4'h9: rdMux = rwValue_r[slot[1:0]];
                        default: ;
                    endcase
                end
                if (ctrlSel)
                begin
                    rdMux = rwCtrl_r[slot[1:0]];
                end
            end
        endcase
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic [31:0] psRdata_r;
    logic psRvalid_r;
    logic psDenied_r;
    logic [NUM_WATCH-1:0] watchHit_r;
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            psRdata_r <= `REG_RESET_ZERO;
            psRvalid_r <= 1'b0;
            psDenied_r <= 1'b0;
            watchHit_r <= '0;
        end
        else
        begin
            psRdata_r <= rdEn ? rdMux : `REG_RESET_ZERO;
            psRvalid_r <= rdEn;
            psDenied_r <= (psReq.read || psReq.write) && !dbgOk;
            watchHit_r <= hit;
        end
    end

    logic [7:0] suspendDec;
    assign suspendDec = (state_r == DEBUG_ST) ? (8'h01 << stopCore_r) : 8'h00;
    assign psRdata = psRdata_r;
    assign psRvalid = psRvalid_r;
    assign psDenied = psDenied_r;
    assign debugActive = state_r == DEBUG_ST;
    assign coreSuspend = suspendDec;
    assign watchHit = watchHit_r;
    assign ramBase = ramBase_r;
    assign vectorBase = vectorBase_r;
    assign tileControl = tileControl_r;
    assign ringOscControl = ringOscControl_r;
endmodule

// File: tile_status_cfg.svh
// Register offsets, field positions, reset values and sizes of the tile status register bank.
`ifndef TILE_STATUS_CFG_SVH
`define TILE_STATUS_CFG_SVH

`define PS_ADDR_W 8
`define PS_RAM_BASE 8'h00
`define PS_VECTOR_BASE 8'h01
`define PS_TILE_CONTROL 8'h02
`define PS_TILE_BOOT_STATUS 8'h03
`define PS_SECURITY_CONFIG 8'h05
`define PS_RING_OSC_CONTROL 8'h06
`define PS_RING_OSC_COUNT_A 8'h07
`define PS_RING_OSC_TILE_WIRE 8'h08
`define PS_RING_OSC_PERIPH_CELL 8'h09
`define PS_RING_OSC_PERIPH_WIRE 8'h0A
`define PS_DEBUG_SAVED_STATUS 8'h10
`define PS_DEBUG_SAVED_PC 8'h11
`define PS_DEBUG_SAVED_SP 8'h12
`define PS_DEBUG_FETCH_OP_ONE 8'h13
`define PS_DEBUG_FETCH_OP_TWO 8'h14
`define PS_DEBUG_INT_TYPE 8'h15
`define PS_DEBUG_INT_DATA 8'h16
`define PS_DEBUG_CORE_CONTROL 8'h18
`define PS_DEBUG_SCRATCH_BASE 8'h20
`define PS_INSTR_BP_ADDR_BASE 8'h30
`define PS_INSTR_BP_CTRL_BASE 8'h40
`define PS_DATA_WATCH_ONE_BASE 8'h50
`define PS_DATA_WATCH_TWO_BASE 8'h60
`define PS_DATA_BP_CTRL_BASE 8'h70
`define PS_RES_WATCH_MASK_BASE 8'h80
`define PS_RES_WATCH_VALUE_BASE 8'h90
`define PS_RES_WATCH_CTRL_BASE 8'h9C

`define RW_CTRL_ENABLE_BIT 0
`define RW_CTRL_SENSE_BIT 1
`define RW_CTRL_CORE_LSB 16
`define RW_CTRL_CORE_MSB 23
`define RW_CTRL_WRITE_MASK 32'h00FF0003
`define RING_COUNT_MASK 32'h0000FFFF
`define REG_RESET_ZERO 32'h00000000

`endif

// File: tile_status_pkg.sv
// Types shared by the tile status register bank.
package tile_status_pkg;

    typedef struct packed {
        logic read;
        logic write;
        logic debugMode;
        logic [7:0] addr;
        logic [31:0] wdata;
    } ps_req_s;

    typedef struct packed {
        logic valid;
        logic [2:0] core;
        logic [31:0] resourceId;
        logic [31:0] savedStatusWord;
        logic [31:0] savedProgramCounter;
        logic [31:0] savedStackPointer;
    } res_access_s;

    typedef enum logic [0:0] {
        RUN_ST = 1'b0,
        DEBUG_ST = 1'b1
    } dbg_state_e;

endpackage

// File: tile_status_assertions.sv
// Concurrent checks on the ports of the tile status register bank.
`timescale 1ns/1ps
`include "tile_status_cfg.svh"
module tile_status_assertions #(
    parameter int NUM_WATCH = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire tile_status_pkg::ps_req_s psReq,
    input wire logic [31:0] psRdata,
    input wire logic psRvalid,
    input wire logic psDenied,
    input wire tile_status_pkg::res_access_s resAccess,
    input wire logic [3:0][15:0] ringCount,
    input wire logic debugExit,
    input wire logic debugActive,
    input wire logic [7:0] coreSuspend,
    input wire logic [NUM_WATCH-1:0] watchHit
);
    import tile_status_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    wire logic inDebugRegion = psReq.addr >= `PS_DEBUG_SAVED_STATUS;
    property p_readAnswer;
        psReq.read && (!inDebugRegion || psReq.debugMode) |=> psRvalid && !psDenied;
    endproperty
    a_readAnswer: assert property (p_readAnswer) else $error("read not answered");
    property p_refused;
        (psReq.read || psReq.write) && inDebugRegion && !psReq.debugMode |=> psDenied && !psRvalid;
    endproperty
    a_refused: assert property (p_refused) else $error("debug access not refused");
    property p_answerCause;
        psRvalid |-> $past(psReq.read);
    endproperty
    a_answerCause: assert property (p_answerCause) else $error("answer without read");
    property p_ringWire;
        psReq.read && psReq.addr == `PS_RING_OSC_TILE_WIRE |=> psRdata == {16'h0000, $past(ringCount[1], 2)};
    endproperty
    a_ringWire: assert property (p_ringWire) else $error("tile wire count wrong");
    property p_ringPeriph;
        psReq.read && psReq.addr == `PS_RING_OSC_PERIPH_WIRE |=> psRdata == {16'h0000, $past(ringCount[3], 2)};
    endproperty
    a_ringPeriph: assert property (p_ringPeriph) else $error("periph wire count wrong");
    property p_hitEnters;
        watchHit != '0 |-> debugActive && $onehot(coreSuspend);
    endproperty
    a_hitEnters: assert property (p_hitEnters) else $error("hit did not suspend one core");
    property p_entryCause;
        $rose(debugActive) |-> $past(resAccess.valid) && watchHit != '0;
    endproperty
    a_entryCause: assert property (p_entryCause) else $error("debug entered without hit");
    property p_quietInDebug;
        debugActive && !debugExit && resAccess.valid |=> watchHit == '0;
    endproperty
    a_quietInDebug: assert property (p_quietInDebug) else $error("hit while in debug");
    property p_exit;
        debugActive && debugExit |=> !debugActive && coreSuspend == 8'h00;
    endproperty
    a_exit: assert property (p_exit) else $error("debug exit ignored");
    property p_idle;
        !debugActive |-> coreSuspend == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("core stopped outside debug");
endmodule

// File: core_model.sv
// Behavioural processor core issuing status reads, writes and resource accesses.
`timescale 1ns/1ps
module core_model (
    input wire logic clk_sys,
    output tile_status_pkg::ps_req_s psReq,
    output tile_status_pkg::res_access_s resAccess,
    input wire logic [31:0] psRdata,
    input wire logic psRvalid,
    input wire logic psDenied
);
    import tile_status_pkg::*;
    initial
    begin
        psReq = '0;
        resAccess = '0;
    end
    // Status instructions and resource accesses are the only paths into the bank; no memory access exists here.
    task automatic psOp(input logic wr, input logic dm, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic rv, output logic dn);
        @(posedge clk_sys);
        #1;
        psReq = '{read: !wr, write: wr, debugMode: dm, addr: a, wdata: d};
        @(posedge clk_sys);
        #1;
        rd = psRdata;
        rv = psRvalid;
        dn = psDenied;
        // Released lines carry inverted values, so a stale address cannot pass for a live one.
        psReq = '{read: 1'b0, write: 1'b0, debugMode: !dm, addr: ~a, wdata: ~d};
    endtask
    task automatic resOp(input logic [2:0] c, input logic [31:0] id, input logic [31:0] sw, input logic [31:0] pc);
        @(posedge clk_sys);
        #1;
        resAccess = '{valid: 1'b1, core: c, resourceId: id, savedStatusWord: sw,
                      savedProgramCounter: pc, savedStackPointer: ~pc};
        @(posedge clk_sys);
        #1;
        resAccess = '{valid: 1'b0, core: ~c, resourceId: ~id, savedStatusWord: ~sw,
                      savedProgramCounter: ~pc, savedStackPointer: pc};
    endtask
endmodule

// File: tb_tile_status_debug_registers.sv
// Self-checking bench for the tile status register bank.
`timescale 1ns/1ps
module tb_tile_status_debug_registers;
    import tile_status_pkg::*;
    typedef struct packed {logic [7:0] a; logic dm; logic [31:0] w; logic [31:0] e;} row_s;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic debugExit = 1'b0;
    logic [3:0][15:0] ringCount = {16'h4D4D, 16'hC3C3, 16'h5A5A, 16'h1234};
    ps_req_s psReq;
    res_access_s resAccess;
    logic [31:0] psRdata, ramBase, vectorBase, tileControl, ringOscControl, rd;
    logic psRvalid, psDenied, debugActive, rv, dn;
    logic [7:0] coreSuspend;
    logic [3:0] watchHit;
    int fails = 0;
    int n_tests = 0;
    row_s rows [16] = '{
        '{8'h00, 1'b0, 32'hA5A50F0F, 32'hA5A50F0F}, '{8'h01, 1'b0, 32'h3C3C1111, 32'h3C3C1111},
        '{8'h02, 1'b0, 32'h00FF00FF, 32'h00FF00FF}, '{8'h06, 1'b0, 32'h12345678, 32'h12345678},
        '{8'h03, 1'b0, 32'hFFFFFFFF, 32'h00000000}, '{8'h05, 1'b0, 32'hFFFFFFFF, 32'h00000000},
        '{8'h04, 1'b0, 32'hFFFFFFFF, 32'h00000000}, '{8'h07, 1'b0, 32'hFFFFFFFF, 32'h00001234},
        '{8'h12, 1'b1, 32'hCAFE0001, 32'hCAFE0001}, '{8'h27, 1'b1, 32'h01020304, 32'h01020304},
        '{8'h28, 1'b1, 32'hFFFFFFFF, 32'h00000000}, '{8'h43, 1'b1, 32'h89ABCDEF, 32'h89ABCDEF},
        '{8'h83, 1'b1, 32'h0000FFFF, 32'h0000FFFF}, '{8'h93, 1'b1, 32'h87654321, 32'h87654321},
        '{8'h9F, 1'b1, 32'hFFFFFFFF, 32'h00FF0003}, '{8'hA1, 1'b1, 32'hFFFFFFFF, 32'h00000000}};
    always #20 clk_sys = ~clk_sys;
    core_model core_model_i (.clk_sys(clk_sys), .psReq(psReq), .resAccess(resAccess), .psRdata(psRdata),
                             .psRvalid(psRvalid), .psDenied(psDenied));
    tile_status_debug_registers tile_status_debug_registers_i (.clk_sys(clk_sys), .rst_n(rst_n), .psReq(psReq),
        .psRdata(psRdata), .psRvalid(psRvalid), .psDenied(psDenied), .resAccess(resAccess), .ringCount(ringCount),
        .debugExit(debugExit), .debugActive(debugActive), .coreSuspend(coreSuspend), .watchHit(watchHit),
        .ramBase(ramBase), .vectorBase(vectorBase), .tileControl(tileControl), .ringOscControl(ringOscControl));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic hit(input logic [2:0] c, input logic [31:0] id, input logic [3:0] e);
        core_model_i.resOp(c, id, 32'h0000A0A0, 32'h00400100);
        check({28'h0000000, watchHit}, {28'h0000000, e});
    endtask
    task automatic leave;
        @(posedge clk_sys);
        #1;
        debugExit = 1'b1;
        @(posedge clk_sys);
        #1;
        debugExit = 1'b0;
        check({31'h00000000, debugActive}, 32'h00000000);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        summarize();
    end
    initial
    begin
        repeat (6) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        core_model_i.psOp(1'b0, 1'b1, 8'h9C, 32'h0, rd, rv, dn);
        check(rd, 32'h00000000);
        core_model_i.psOp(1'b0, 1'b0, 8'h10, 32'h0, rd, rv, dn);
        check({30'h0, rv, dn}, 32'h00000001);
        foreach (rows[i])
        begin
            core_model_i.psOp(1'b1, rows[i].dm, rows[i].a, rows[i].w, rd, rv, dn);
            core_model_i.psOp(1'b0, rows[i].dm, rows[i].a, 32'h0, rd, rv, dn);
            check({rv, rd}, {1'b1, rows[i].e});
        end
        check(ramBase, 32'hA5A50F0F);
        check(vectorBase, 32'h3C3C1111);
        check(tileControl, 32'h00FF00FF);
        check(ringOscControl, 32'h12345678);
        for (int i = 1; i < 4; i++)
        begin
            core_model_i.psOp(1'b0, 1'b0, 8'h07 + 8'(i), 32'h0, rd, rv, dn);
            check(rd, {16'h0000, ringCount[i]});
        end
        // Release and the first read share one edge, so a cleared count would show at once.
        @(posedge clk_sys);
        #1;
        rst_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        fork
            core_model_i.psOp(1'b0, 1'b0, 8'h08, 32'h0, rd, rv, dn);
            begin
                @(posedge clk_sys);
                #1;
                rst_n = 1'b1;
            end
        join
        check(rd, 32'h00005A5A);
        core_model_i.psOp(1'b1, 1'b1, 8'h80, 32'h0000FFFF, rd, rv, dn);
        core_model_i.psOp(1'b1, 1'b1, 8'h90, 32'h00001234, rd, rv, dn);
        core_model_i.psOp(1'b1, 1'b1, 8'h9C, 32'h00040001, rd, rv, dn);
        hit(3'd2, 32'hABCD1234, 4'b0001);
        check({debugActive, coreSuspend}, 9'h104);
        core_model_i.psOp(1'b0, 1'b1, 8'h10, 32'h0, rd, rv, dn);
        check(rd, 32'h0000A0A0);
        core_model_i.psOp(1'b0, 1'b1, 8'h11, 32'h0, rd, rv, dn);
        check(rd, 32'h00400100);
        leave();
        hit(3'd3, 32'h00001234, 4'b0000);
        hit(3'd2, 32'hABCD1235, 4'b0000);
        core_model_i.psOp(1'b1, 1'b1, 8'h9C, 32'h00040003, rd, rv, dn);
        hit(3'd2, 32'h00001234, 4'b0000);
        hit(3'd2, 32'h00001235, 4'b0001);
        leave();
        core_model_i.psOp(1'b1, 1'b1, 8'h9C, 32'h00040002, rd, rv, dn);
        hit(3'd2, 32'h00001235, 4'b0000);
        summarize();
    end
endmodule
bind tile_status_debug_registers tile_status_assertions #(.NUM_WATCH(NUM_WATCH)) tile_status_assertions_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .psReq(psReq), .psRdata(psRdata), .psRvalid(psRvalid),
    .psDenied(psDenied), .resAccess(resAccess), .ringCount(ringCount), .debugExit(debugExit),
    .debugActive(debugActive), .coreSuspend(coreSuspend), .watchHit(watchHit));
